// [core/mac_map.svh]
// Register offsets and reset values of the MAC unit
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH
`define MAC_ADDR_MULT_X 8'hE8
`define MAC_ADDR_MULT_Y 8'hE9
`define MAC_ADDR_PROD_HI 8'hEA
`define MAC_ADDR_PROD_LO 8'hEB
`define MAC_ADDR_ACC_B1 8'hEC
`define MAC_ADDR_ACC_B0 8'hED
`define MAC_ADDR_ACC_B3 8'hEE
`define MAC_ADDR_ACC_B2 8'hEF
`define MAC_RESET_BYTE 8'h00
`define MAC_RESET_ACC 32'h0000_0000
`define MAC_RESET_PROD 16'h0000
`endif

// [core/mac_pkg.sv]
// Types shared by the MAC unit
package mac_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [7:0] addr_t;
   typedef logic signed [15:0] prod_t;
   typedef logic signed [31:0] acc_t;
endpackage : mac_pkg

// [core/signed_mac.sv]
// Signed 8x8 multiply and 32-bit multiply-accumulate on the register bus
`timescale 1ns/1ps
`include "mac_map.svh"

// Notes on behaviour
// - All arithmetic is signed two's complement.
// - 8-bit operands, 16-bit product, 32-bit accumulator.
// - Multiply-only write updates product, not accumulator.
// - Accumulate write adds product into accumulator.
// - Both X addresses share X; Y likewise.
// - Write to either clear address zeroes accumulator.
// - Product and low bytes immediate; high bytes lag.
// - Product readback needs no spacing.
// - Product high at EAh, low at EBh.
// - ECh reads bits 15:8, EDh bits 7:0.
// - Multiply-only operands write-only at E8h, E9h.
// - Attached directly to CPU internal data bus.
// - EEh reads bits 31:24; write clears.
// - EFh reads bits 23:16; write clears.
module signed_mac (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   // CPU register bus
   input wire mac_pkg::addr_t ADDR_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire mac_pkg::byte_t WDATA_I,
   output mac_pkg::byte_t RDATA_O
);
   import mac_pkg::*;

   // ----------------------------------------------------------------
   // Operand and result state
   // ----------------------------------------------------------------
   // operand, product and accumulator widths
   byte_t x_q, x_d, y_q, y_d;
   prod_t prod_q, prod_d;
   logic [15:0] acc_lo_q, acc_lo_d;
   logic [15:0] acc_hi_q, acc_hi_d;
   logic carry_q, carry_d;
   logic [15:0] hi_add_q, hi_add_d;
   logic hi_pend_q, hi_pend_d;

   logic wr_mx, wr_my, wr_ax, wr_ay, wr_clr, acc_go;
   byte_t nx, ny;
   prod_t nprod;
   logic [16:0] lo_sum;

   function automatic prod_t smul(input byte_t a, input byte_t b);
      prod_t ea;
      prod_t eb;
      // sign-extend both operands before the product
      ea = prod_t'($signed(a));
      eb = prod_t'($signed(b));
      smul = ea * eb;
   endfunction : smul

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   // direct bus decode
   assign wr_mx = WR_I && ADDR_I == `MAC_ADDR_MULT_X;
   assign wr_my = WR_I && ADDR_I == `MAC_ADDR_MULT_Y;
   assign wr_ax = WR_I && ADDR_I == `MAC_ADDR_ACC_B1;
   assign wr_ay = WR_I && ADDR_I == `MAC_ADDR_ACC_B0;
   assign wr_clr = WR_I && (ADDR_I == `MAC_ADDR_ACC_B3
                            || ADDR_I == `MAC_ADDR_ACC_B2);
   assign acc_go = wr_ax || wr_ay;

   always_comb begin
      nx = (wr_mx || wr_ax) ? WDATA_I : x_q;
      ny = (wr_my || wr_ay) ? WDATA_I : y_q;
      nprod = smul(nx, ny);
      // low half of the wrapping sum
      lo_sum = {1'b0, acc_lo_q} + {1'b0, nprod};
      x_d = nx;
      y_d = ny;
      prod_d = prod_q;
      acc_lo_d = acc_lo_q;
      acc_hi_d = acc_hi_q;
      carry_d = 1'b0;
      hi_add_d = 16'h0000;
      hi_pend_d = 1'b0;
      // upper half finishes one cycle later
      if (hi_pend_q) begin
         acc_hi_d = acc_hi_q + hi_add_q + {15'h0000, carry_q};
      end
      // product ready at the write edge
      if (wr_mx || wr_my || acc_go) begin
         prod_d = nprod;
      end
      if (acc_go) begin
         acc_lo_d = lo_sum[15:0];
         carry_d = lo_sum[16];
         hi_add_d = {16{nprod[15]}};
         hi_pend_d = 1'b1;
      end
      if (wr_clr) begin
         acc_lo_d = 16'h0000;
         acc_hi_d = 16'h0000;
         hi_pend_d = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         x_q <= `MAC_RESET_BYTE;
         y_q <= `MAC_RESET_BYTE;
         prod_q <= `MAC_RESET_PROD;
         acc_lo_q <= 16'h0000;
         acc_hi_q <= 16'h0000;
         carry_q <= 1'b0;
         hi_add_q <= 16'h0000;
         hi_pend_q <= 1'b0;
      end else begin
         x_q <= x_d;
         y_q <= y_d;
         prod_q <= prod_d;
         acc_lo_q <= acc_lo_d;
         acc_hi_q <= acc_hi_d;
         carry_q <= carry_d;
         hi_add_q <= hi_add_d;
         hi_pend_q <= hi_pend_d;
      end
   end

   // ----------------------------------------------------------------
   // Read mux, registered
   // ----------------------------------------------------------------
   byte_t rdata_q, rdata_d;
   always_comb begin
      rdata_d = rdata_q;
      if (RD_I) begin
         unique case (ADDR_I)
            `MAC_ADDR_PROD_HI: rdata_d = prod_q[15:8];
            `MAC_ADDR_PROD_LO: rdata_d = prod_q[7:0];
            `MAC_ADDR_ACC_B1: rdata_d = acc_lo_q[15:8];
            `MAC_ADDR_ACC_B0: rdata_d = acc_lo_q[7:0];
            `MAC_ADDR_ACC_B3: rdata_d = acc_hi_q[15:8];
            `MAC_ADDR_ACC_B2: rdata_d = acc_hi_q[7:0];
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         rdata_q <= `MAC_RESET_BYTE;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign RDATA_O = rdata_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);

   prod_update_a: assert property (
      (wr_mx || wr_my) |=> prod_q == smul(x_q, y_q))
      else $error("product not updated");
   acc_hold_a: assert property (
      (wr_mx || wr_my) && !hi_pend_q |=> $stable({acc_hi_q, acc_lo_q}))
      else $error("multiply-only changed accumulator");
   acc_add_a: assert property (
      acc_go && !hi_pend_q ##1 !(acc_go || wr_clr) |=>
      {acc_hi_q, acc_lo_q} == $past({acc_hi_q, acc_lo_q}, 2)
      + {{16{$past(prod_q[15])}}, $past(prod_q)})
      else $error("accumulate sum wrong");
   shared_x_a: assert property (
      wr_ax |=> x_q == $past(WDATA_I))
      else $error("shared x not loaded");
   clear_a: assert property (
      wr_clr |=> acc_lo_q == 16'h0000 && acc_hi_q == 16'h0000)
      else $error("clear failed");
   lo_now_a: assert property (
      acc_go && !wr_clr |=> acc_lo_q
      == 16'($past(acc_lo_q) + $past(nprod)))
      else $error("low bytes late");
   read_top_a: assert property (
      RD_I && ADDR_I == `MAC_ADDR_ACC_B3 |=> RDATA_O == $past(acc_hi_q[15:8]))
      else $error("top byte read wrong");
   read_prod_a: assert property (
      RD_I && ADDR_I == `MAC_ADDR_PROD_LO |=> RDATA_O == $past(prod_q[7:0]))
      else $error("product low read wrong");
   read_wo_a: assert property (
      RD_I && ADDR_I == `MAC_ADDR_MULT_X |=> RDATA_O == 8'h00)
      else $error("write-only read nonzero");
   prod_now_a: assert property (
      wr_mx |=> prod_q == $signed($past(WDATA_I)) * $signed($past(y_q)))
      else $error("product not ready after write");
   shared_y_a: assert property (
      wr_my |=> y_q == $past(WDATA_I))
      else $error("shared y not loaded");
   read_mid_a: assert property (
      RD_I && ADDR_I == `MAC_ADDR_ACC_B1
      |=> RDATA_O == $past(acc_lo_q[15:8]))
      else $error("accumulator byte 1 read wrong");
   read_low_a: assert property (
      RD_I && ADDR_I == `MAC_ADDR_ACC_B0
      |=> RDATA_O == $past(acc_lo_q[7:0]))
      else $error("accumulator byte 0 read wrong");
   read_next_a: assert property (
      RD_I && ADDR_I == `MAC_ADDR_ACC_B2
      |=> RDATA_O == $past(acc_hi_q[7:0]))
      else $error("accumulator byte 2 read wrong");

   mult_c: cover property (wr_my ##2 wr_mx);
   mac_c: cover property (wr_mx ##2 wr_ay);
   clr_c: cover property (acc_go ##2 wr_clr);
   hi_read_c: cover property (
      acc_go ##2 (RD_I && ADDR_I == `MAC_ADDR_ACC_B3));
endmodule : signed_mac

// [verif/cpu_model.sv]
// CPU register bus model driving the MAC unit
`timescale 1ns/1ps
module cpu_model (
   // Bus
   input wire logic clk_i,
   input wire mac_pkg::byte_t rdata_i,
   output mac_pkg::addr_t addr_o,
   output logic wr_o,
   output logic rd_o,
   output mac_pkg::byte_t wdata_o
);
   import mac_pkg::*;
   initial begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
   end
   task automatic wr(input addr_t a, input byte_t d);
      @(posedge clk_i);
      addr_o <= a;
      wr_o <= 1'b1;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
   endtask : wr
   task automatic rd(input addr_t a, output byte_t d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1 d = rdata_i;
   endtask : rd
endmodule : cpu_model

// [verif/tb_top.sv]
// Self-checking testbench of the MAC unit
`timescale 1ns/1ps
`include "mac_map.svh"
module tb_top;
   import mac_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   addr_t addr;
   logic wr;
   logic rd;
   byte_t wdata;
   byte_t rdata;
   int bad_count = 0;
   int checked = 0;
   acc_t exp_acc = 32'h0;
   prod_t exp_prod = 16'h0;
   always #5 ref_clk = ~ref_clk;
   cpu_model cpu (.clk_i(ref_clk), .rdata_i(rdata), .addr_o(addr),
      .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
   signed_mac DUT (.REF_CLK_I(ref_clk), .RESET_I(reset), .ADDR_I(addr),
      .WR_I(wr), .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata));
   task automatic check(input byte_t seen, input byte_t want);
      checked++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic rd_chk(input addr_t a, input byte_t want);
      byte_t d;
      cpu.rd(a, d);
      check(d, want);
   endtask : rd_chk
   task automatic mac(input byte_t x, input byte_t y);
      exp_prod = $signed(x) * $signed(y);
      exp_acc = exp_acc + acc_t'(exp_prod);
      cpu.wr(`MAC_ADDR_MULT_X, x);
      cpu.wr(`MAC_ADDR_ACC_B0, y);
   endtask : mac
   task automatic acc_chk();
      rd_chk(`MAC_ADDR_ACC_B3, exp_acc[31:24]);
      rd_chk(`MAC_ADDR_ACC_B2, exp_acc[23:16]);
      rd_chk(`MAC_ADDR_ACC_B1, exp_acc[15:8]);
      rd_chk(`MAC_ADDR_ACC_B0, exp_acc[7:0]);
      rd_chk(`MAC_ADDR_PROD_HI, exp_prod[15:8]);
      rd_chk(`MAC_ADDR_PROD_LO, exp_prod[7:0]);
   endtask : acc_chk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      for (int a = 8'hE8; a <= 8'hEF; a++) begin
         rd_chk(addr_t'(a), 8'h00);
      end
      rd_chk(8'h00, 8'h00);
      cpu.wr(`MAC_ADDR_MULT_Y, 8'h07);
      cpu.wr(`MAC_ADDR_MULT_X, 8'hFD);
      rd_chk(`MAC_ADDR_PROD_HI, 8'hFF);
      rd_chk(`MAC_ADDR_PROD_LO, 8'hEB);
      rd_chk(`MAC_ADDR_ACC_B0, 8'h00);
      rd_chk(`MAC_ADDR_MULT_X, 8'h00);
      cpu.wr(`MAC_ADDR_PROD_LO, 8'h55);
      rd_chk(`MAC_ADDR_PROD_LO, 8'hEB);
      mac(8'h80, 8'h80);
      acc_chk();
      mac(8'h80, 8'h7F);
      mac(8'h81, 8'h7F);
      acc_chk();
      cpu.wr(`MAC_ADDR_ACC_B3, 8'hA5);
      exp_acc = 32'h0;
      acc_chk();
      cpu.wr(`MAC_ADDR_MULT_Y, 8'h02);
      cpu.wr(`MAC_ADDR_ACC_B1, 8'hFD);
      exp_prod = 16'hFFFA;
      exp_acc = 32'hFFFF_FFFA;
      acc_chk();
      cpu.wr(`MAC_ADDR_ACC_B2, 8'h00);
      exp_acc = 32'h0;
      acc_chk();
      mac(8'h7F, 8'h7F);
      cpu.wr(`MAC_ADDR_ACC_B3, 8'h00);
      exp_acc = 32'h0;
      mac(8'h05, 8'hFB);
      acc_chk();
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      exp_acc = 32'h0;
      exp_prod = 16'h0;
      acc_chk();
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      bad_count++;
      tally_and_finish();
   end
endmodule : tb_top
